// ===== logic/edge_gate_router.sv
`timescale 1ns/10ps
module edge_gate_router import irq_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [3:0] ext_pin, // asynchronous request inputs
  input wire logic [47:0] cfg, // four router_cfg_t words
  output logic [3:0] gate_out // one-cycle requests to nodes
);
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;
  logic [3:0] evt;
  //------------------------------------------------------------
  // two-stage synchroniser and edge history
  //------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev <= 4'h0;
    end else begin
      sync1 <= ext_pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_chan
      router_cfg_t c;
      logic hit;
      logic pass;
      assign c = router_cfg_t'(cfg[k*12 +: 12]);
      // edge trigger per input channel
      assign evt[k] = (c.edge_sel[0] & sync2[k] & ~prev[k]) // [RL12]
                    | (c.edge_sel[1] & ~sync2[k] & prev[k]); // [RL12]
      // gating unit: matrix mask, then pattern test
      assign hit = ((sync2 & c.pmask) == c.pmask); // [RL13]
      always_comb begin
        case (c.pmode)
          2'b00: pass = 1'b1;
          2'b01: pass = hit; // [RL13]
          2'b10: pass = ~hit; // [RL13]
          default: pass = 1'b0;
        endcase
      end
      always_ff @(posedge sys_clk) begin
        if (!rst_n) gate_out[k] <= 1'b0;
        else gate_out[k] <= |(evt & c.emask) & pass; // [RL11]
      end
    end
  endgenerate
endmodule : edge_gate_router

// ===== logic/interrupt_event_trap_system.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module interrupt_event_trap_system import irq_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [15:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic [55:0] dedicated_req, // dedicated source pulses
  input wire logic [15:0] shared_req, // four sources per shared node
  input wire logic [3:0] ext_pin, // async router inputs
  input wire logic [2:0] external_service_request_pin, // async pins
  input wire logic [HW_TRAPS-1:0] hw_trap, // hardware trap pulses
  input wire logic sw_trap_valid, // software trap instruction
  input wire logic [6:0] sw_trap_num, // trap number of it
  input wire logic [3:0] cpu_level, // priority of cpu activity
  input wire logic trap_ret, // trap service returned
  output logic svc_entry, // one-cycle service entry
  output logic [7:0] svc_vector, // vector of that entry
  output logic cpu_steal, // cycle taken by event service
  output xfer_t xfer // event transfer request
);
  node_ctrl_t node [NODES];
  logic [7:0] sel;
  chan_ctrl_t chan [CHANS];
  logic [15:0] src_ptr [CHANS];
  logic [15:0] dst_ptr [CHANS];
  logic [TRAPS-1:0] trap_flag_reg;
  logic [TRAPS-1:0] trap_pend;
  logic [3:0] sys_ctrl;
  logic [47:0] router_cfg;
  logic [3:0] gate_out;
  logic [2:0] esr_s1;
  logic [2:0] esr_s2;
  logic [2:0] esr_prev;
  logic [NODES-1:0] hw_set;
  logic [NODES-1:0] pend;
  logic [NODES*4-1:0] lvl;
  logic found;
  logic [5:0] win;
  logic [3:0] best;
  svc_state_t state;
  logic [7:0] lat_cnt;
  logic [7:0] vec;
  logic trap_active;
  logic [2:0] cur_trap;
  logic trap_found;
  logic [2:0] trap_idx;
  logic grant_trap;
  logic grant_node;
  logic grant_evt;
  logic [2:0] gch;
  logic [NODES-1:0] grant_clr;
  logic [TRAPS-1:0] esr_event;
  logic wr_node;
  logic [5:0] waddr;

  //------------------------------------------------------------
  // external request router
  //------------------------------------------------------------
  edge_gate_router u_router (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ext_pin(ext_pin),
    .cfg(router_cfg),
    .gate_out(gate_out)
  );

  //------------------------------------------------------------
  // node request sources
  //------------------------------------------------------------
  // dedicated, router and shared sources onto nodes
  always_comb begin
    hw_set = '0;
    hw_set[55:0] = dedicated_req;
    hw_set[ROUTER_BASE +: 4] = hw_set[ROUTER_BASE +: 4] | gate_out; // [RL11]
    for (int s = 0; s < SHARED; s++) begin
      hw_set[SHARED_BASE+s] = shared_req[s*4 + int'(sel[s*2 +: 2])]; // [RL10]
    end
  end

  assign wr_node = wr && (addr[7:6] == 2'b00);
  assign waddr = addr[5:0];

  //------------------------------------------------------------
  // arbitration
  //------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < NODES; n++) begin : g_node
      assign pend[n] = node[n].ir & node[n].ie;
      assign lvl[n*4 +: 4] = node[n].lvl;
    end
  endgenerate

  node_arbiter u_arb (
    .pend(pend),
    .lvl(lvl),
    .found(found),
    .idx(win),
    .best(best)
  );

  // highest pending trap, higher index ranks higher
  always_comb begin
    trap_found = 1'b0;
    trap_idx = 3'h0;
    for (int t = 0; t < TRAPS; t++) begin
      if (trap_pend[t]) begin
        trap_found = 1'b1;
        trap_idx = 3'(t);
      end
    end
  end

  // grant decisions, only from idle
  assign grant_trap = (state == S_IDLE) && trap_found
    && (!trap_active || trap_idx > cur_trap); // [RL16]
  assign grant_node = (state == S_IDLE) && !grant_trap && !trap_active // [RL17]
    && found && (best > cpu_level) && !sw_trap_valid; // [RL21]
  assign gch = node[win].ch;
  // event route only while the channel still has transfers left
  assign grant_evt = grant_node && node[win].evt // [RL1]
    && (chan[gch].cont || chan[gch].cnt != 8'h00); // [RL6]

  // flag cleared when its node is taken
  always_comb begin
    grant_clr = '0;
    if (grant_node) grant_clr[win] = 1'b1;
  end

  //------------------------------------------------------------
  // node control registers
  //------------------------------------------------------------
  // hardware set wins over software or grant clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NODES; i++) node[i] <= '0;
    end else begin
      for (int i = 0; i < NODES; i++) begin
        if (wr_node && waddr == 6'(i)) begin
          node[i] <= node_ctrl_t'(wdata[9:0]);
          node[i].ir <= wdata[9] | hw_set[i]; // [RL20]
        end else begin
          node[i].ir <= (node[i].ir & ~grant_clr[i]) | hw_set[i]; // [RL9]
        end
      end
    end
  end

  // source selection of shared nodes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) sel <= 8'h00;
    else if (wr && addr[7:2] == A_SEL[7:2]) begin
      sel[addr[1:0]*2 +: 2] <= wdata[1:0]; // [RL10]
    end
  end

  // router and system control
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      router_cfg <= '0;
      sys_ctrl <= 4'h0;
    end else if (wr) begin
      if (addr[7:2] == A_ROUTER[7:2]) router_cfg[addr[1:0]*12 +: 12] <= wdata[11:0];
      if (addr == A_SYS_CTRL) sys_ctrl <= wdata[3:0];
    end
  end

  //------------------------------------------------------------
  // event transfer channels
  //------------------------------------------------------------
  // one channel updated per service, software writes otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANS; c++) begin // [RL7]
        chan[c] <= '0;
        src_ptr[c] <= 16'h0000;
        dst_ptr[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (grant_evt && gch == 3'(c)) begin
          if (chan[c].inc_src) // [RL4]
            src_ptr[c] <= src_ptr[c] + (chan[c].word ? 16'h0002 : 16'h0001);
          if (chan[c].inc_dst) // [RL4]
            dst_ptr[c] <= dst_ptr[c] + (chan[c].word ? 16'h0002 : 16'h0001);
          if (!chan[c].cont) chan[c].cnt <= chan[c].cnt - 8'h01; // [RL5]
        end else if (wr && addr[7:5] == A_CH[7:5] && addr[4:2] == 3'(c)) begin
          case (addr[1:0])
            2'b00: chan[c] <= chan_ctrl_t'(wdata[11:0]);
            2'b01: src_ptr[c] <= wdata;
            2'b10: dst_ptr[c] <= wdata;
            default: ;
          endcase
        end
      end
    end
  end

  // transfer request lasts the stolen cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      xfer <= '0;
    end else begin
      xfer.valid <= grant_evt; // [RL3]
      if (grant_evt) begin
        xfer.word <= chan[gch].word; // [RL4]
        xfer.src <= src_ptr[gch];
        xfer.dst <= dst_ptr[gch];
      end
    end
  end

  //------------------------------------------------------------
  // service request pins and traps
  //------------------------------------------------------------
  // pins synchronised, rising edge requests a system trap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      esr_s1 <= 3'h0;
      esr_s2 <= 3'h0;
      esr_prev <= 3'h0;
    end else begin
      esr_s1 <= external_service_request_pin;
      esr_s2 <= esr_s1;
      esr_prev <= esr_s2;
    end
  end

  // pin 0 gives the first system request, pins 1 and 2 the second
  always_comb begin
    esr_event = '0;
    esr_event[HW_TRAPS-1:0] = hw_trap; // [RL15]
    esr_event[SR0_BIT] = sys_ctrl[1] & esr_s2[0] & ~esr_prev[0]; // [RL18]
    esr_event[SR1_BIT] = esr_event[SR1_BIT]
      | (|(sys_ctrl[3:2] & esr_s2[2:1] & ~esr_prev[2:1])); // [RL18]
  end

  // flags are write-one-to-clear; a new trap wins the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trap_flag_reg <= '0;
    end else if (wr && addr == A_TRAP_FLAG) begin
      trap_flag_reg <= (trap_flag_reg & ~wdata[TRAPS-1:0]) | esr_event; // [RL15]
    end else begin
      trap_flag_reg <= trap_flag_reg | esr_event; // [RL15]
    end
  end

  // pending traps drop when taken
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trap_pend <= '0;
    end else begin
      for (int t = 0; t < TRAPS; t++) begin
        trap_pend[t] <= (trap_pend[t] & ~(grant_trap && trap_idx == 3'(t)))
          | esr_event[t];
      end
    end
  end

  // trap service in progress and its rank
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trap_active <= 1'b0;
      cur_trap <= 3'h0;
    end else if (grant_trap) begin
      trap_active <= 1'b1; // [RL17]
      cur_trap <= trap_idx;
    end else if (trap_ret) begin
      trap_active <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // service sequencer
  //------------------------------------------------------------
  // latency from flag to entry, shortened by the jump cache
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      lat_cnt <= 8'h00;
      vec <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (grant_trap) begin
            state <= S_LAT;
            vec <= TRAP_VEC_BASE + 8'(trap_idx); // [RL14]
          end else if (grant_evt) begin
            state <= S_EVT; // [RL3]
          end else if (grant_node) begin
            state <= S_LAT;
            vec <= 8'(win); // [RL2] [RL6]
          end else if (sw_trap_valid) begin
            state <= S_LAT;
            vec <= 8'(sw_trap_num); // [RL19]
          end
          lat_cnt <= (sys_ctrl[0] ? LAT_JC : LAT_NOJC) - LAT_PIPE; // [RL8]
        end
        S_LAT: begin
          if (lat_cnt == 8'h00) state <= S_ENTRY; // [RL8]
          else lat_cnt <= lat_cnt - 8'h01;
        end
        S_ENTRY: state <= S_IDLE;
        S_EVT: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // entry pulse and vector to the cpu
  assign svc_entry = (state == S_ENTRY); // [RL2]
  assign svc_vector = vec;
  assign cpu_steal = (state == S_EVT); // [RL3]

  //------------------------------------------------------------
  // register read port
  //------------------------------------------------------------
  // read data held for one cycle only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (!rd) begin
      rdata <= 16'h0000;
    end else if (addr[7:6] == 2'b00) begin
      rdata <= {6'h00, node[addr[5:0]]};
    end else if (addr[7:2] == A_SEL[7:2]) begin
      rdata <= {14'h0000, sel[addr[1:0]*2 +: 2]};
    end else if (addr[7:5] == A_CH[7:5]) begin
      case (addr[1:0])
        2'b00: rdata <= {4'h0, chan[addr[4:2]]};
        2'b01: rdata <= src_ptr[addr[4:2]];
        2'b10: rdata <= dst_ptr[addr[4:2]];
        default: rdata <= 16'h0000;
      endcase
    end else if (addr == A_TRAP_FLAG) begin
      rdata <= {8'h00, trap_flag_reg};
    end else if (addr == A_SYS_CTRL) begin
      rdata <= {12'h000, sys_ctrl};
    end else if (addr == A_STATUS) begin
      rdata <= {10'h000, cur_trap, trap_active, state};
    end else if (addr[7:2] == A_ROUTER[7:2]) begin
      rdata <= {4'h0, router_cfg[addr[1:0]*12 +: 12]};
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule : interrupt_event_trap_system

// ===== logic/irq_pkg.sv
//------------------------------------------------------------
// interrupt, event transfer and trap constants
//------------------------------------------------------------
// Function
// (RL1) node routes to vector or event channel
// (RL2) standard service jumps to node vector
// (RL3) event service steals exactly one cycle
// (RL4) move byte/word, bump chosen pointers
// (RL5) counter decrements unless continuous mode
// (RL6) counter zero gives standard interrupt
// (RL7) eight independent event transfer channels
// (RL8) entry latency 7 or 11 clocks
// (RL9) 64 nodes with flag, enable, priority
// (RL10) shared nodes pick source by select
// (RL11) router: 4 inputs, matrix, 4 gates
// (RL12) edge detect rising, falling or both
// (RL13) gate passes on pattern match/miss
// (RL14) hardware trap jumps to own vector
// (RL15) each trap sets own flag bit
// (RL16) trap preempts unless higher trap runs
// (RL17) trap service blocks interrupts, events
// (RL18) three request pins make two traps
// (RL19) software trap uses given trap number
// (RL20) software flag write acts as request
// (RL21) highest enabled priority above cpu wins
package irq_pkg;
  localparam int NODES = 64;
  localparam int CHANS = 8;
  localparam int SHARED = 4;
  localparam int SHARED_BASE = 60;
  localparam int ROUTER_BASE = 56;
  localparam int HW_TRAPS = 6;
  localparam int TRAPS = 8;
  localparam logic [7:0] LAT_JC = 8'h07;
  localparam logic [7:0] LAT_NOJC = 8'h0B;
  localparam logic [7:0] LAT_PIPE = 8'h03;
  localparam logic [7:0] TRAP_VEC_BASE = 8'h40;
  localparam logic [7:0] A_SEL = 8'h40;
  localparam logic [7:0] A_CH = 8'h80;
  localparam logic [7:0] A_TRAP_FLAG = 8'hC0;
  localparam logic [7:0] A_SYS_CTRL = 8'hC1;
  localparam logic [7:0] A_STATUS = 8'hC2;
  localparam logic [7:0] A_ROUTER = 8'hC4;
  localparam int SR0_BIT = 7;
  localparam int SR1_BIT = 6;
  typedef struct packed {
    logic ir; logic ie; logic [2:0] ch; logic evt; logic [3:0] lvl;
  } node_ctrl_t;
  typedef struct packed {
    logic word; logic inc_dst; logic inc_src; logic cont; logic [7:0] cnt;
  } chan_ctrl_t;
  typedef struct packed {
    logic [1:0] pmode; logic [3:0] pmask; logic [3:0] emask; logic [1:0] edge_sel;
  } router_cfg_t;
  typedef struct packed {
    logic valid; logic word; logic [15:0] src; logic [15:0] dst;
  } xfer_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_LAT = 2'b01, S_ENTRY = 2'b11, S_EVT = 2'b10
  } svc_state_t;
endpackage : irq_pkg

// ===== logic/node_arbiter.sv
`timescale 1ns/10ps
module node_arbiter import irq_pkg::*; (
  input wire logic [NODES-1:0] pend, // pending and enabled nodes
  input wire logic [NODES*4-1:0] lvl, // priority of each node
  output logic found, // some node pending
  output logic [5:0] idx, // winning node
  output logic [3:0] best // winning priority
);
  //------------------------------------------------------------
  // priority search, lower index wins ties
  //------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    idx = 6'h00;
    best = 4'h0;
    for (int i = 0; i < NODES; i++) begin
      if (pend[i] && (!found || lvl[i*4 +: 4] > best)) begin // [RL21]
        found = 1'b1;
        idx = 6'(i);
        best = lvl[i*4 +: 4];
      end
    end
  end
endmodule : node_arbiter

// ===== tb/cpu_partner.sv
`timescale 1ns/10ps
module cpu_partner import irq_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic svc_entry, // service entry pulse
  input wire logic [7:0] ret_wait, // cycles spent in service
  output logic trap_ret // service return pulse
);
  logic busy;
  logic [7:0] left;
  //----------------------------------------
  // service body and return
  //----------------------------------------
  // each entry starts the handler; a nested entry restarts it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      left <= 8'h00;
      trap_ret <= 1'b0;
    end else begin
      trap_ret <= 1'b0;
      if (svc_entry) begin
        busy <= 1'b1;
        left <= ret_wait;
      end else if (busy && left == 8'h00) begin
        busy <= 1'b0;
        trap_ret <= 1'b1;
      end else if (busy) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule : cpu_partner

// ===== tb/irq_checker.sv
`timescale 1ns/10ps
module irq_checker import irq_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic rd, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic trap_ret, // trap service returned
  input wire logic svc_entry, // service entry pulse
  input wire logic [7:0] svc_vector, // entry vector
  input wire logic cpu_steal, // stolen cpu cycle
  input wire xfer_t xfer // event transfer request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic in_trap;
  logic [7:0] act_vec;
  //----------------------------------------
  // trap service tracking
  //----------------------------------------
  // remembers the trap being served until its return
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_trap <= 1'b0;
      act_vec <= 8'h00;
    end else if (svc_entry && svc_vector[7:3] == 5'h08) begin
      in_trap <= 1'b1;
      act_vec <= svc_vector;
    end else if (trap_ret) begin
      in_trap <= 1'b0;
    end
  end
  //----------------------------------------
  // properties
  //----------------------------------------
  sequence steal_s;
    cpu_steal && xfer.valid;
  endsequence
  sequence trap_entry_s;
    svc_entry && in_trap;
  endsequence
  a_steal_pair: assert property (cpu_steal == xfer.valid)
    else $error("steal and transfer valid differ");
  a_steal_once: assert property (steal_s |=> !cpu_steal)
    else $error("stolen cycle longer than one");
  a_steal_apart: assert property (steal_s |-> !svc_entry)
    else $error("event service with full entry");
  a_entry_once: assert property (svc_entry |=> !svc_entry)
    else $error("entry pulse longer than one");
  a_entry_gap: assert property (svc_entry |=> !cpu_steal)
    else $error("steal right after entry");
  a_read_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data without read");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !svc_entry && !cpu_steal && rdata == 16'h0000)
    else $error("outputs active after reset");
  a_trap_noevt: assert property (in_trap |-> !cpu_steal)
    else $error("event service inside trap");
  a_trap_only: assert property (trap_entry_s |-> svc_vector[7:3] == 5'h08)
    else $error("interrupt entered inside trap");
  a_trap_higher: assert property (trap_entry_s |-> svc_vector > act_vec)
    else $error("lower trap preempted");
  c_steal: cover property (steal_s);
endmodule : irq_checker

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench import irq_pkg::*;;
  logic sys_clk, rst_n, wr, rd, sw_trap_valid, trap_ret, svc_entry, cpu_steal;
  logic [7:0] addr, svc_vector, ret_wait, v;
  logic [15:0] wdata, rdata, shared_req, d;
  logic [55:0] dedicated_req;
  logic [3:0] ext_pin, cpu_level;
  logic [2:0] external_service_request_pin;
  logic [HW_TRAPS-1:0] hw_trap;
  logic [6:0] sw_trap_num;
  xfer_t xfer, x;
  int miscompares, check_count, cycles, n;
  interrupt_event_trap_system dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dedicated_req(dedicated_req),
    .shared_req(shared_req), .ext_pin(ext_pin),
    .external_service_request_pin(external_service_request_pin), .hw_trap(hw_trap),
    .sw_trap_valid(sw_trap_valid), .sw_trap_num(sw_trap_num), .cpu_level(cpu_level),
    .trap_ret(trap_ret), .svc_entry(svc_entry), .svc_vector(svc_vector),
    .cpu_steal(cpu_steal), .xfer(xfer));
  cpu_partner cpu (.sys_clk(sys_clk), .rst_n(rst_n), .svc_entry(svc_entry),
    .ret_wait(ret_wait), .trap_ret(trap_ret));
  //----------------------------------------
  // clock, watchdog and helpers
  //----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // cuts a hung run short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
  task automatic pulse_node(input int i);
    @(posedge sys_clk);
    dedicated_req[i] <= 1'b1;
    @(posedge sys_clk);
    dedicated_req <= 56'h0;
  endtask : pulse_node
  task automatic pulse_trap(input logic [5:0] t);
    @(posedge sys_clk);
    hw_trap <= t;
    @(posedge sys_clk);
    hw_trap <= 6'h00;
  endtask : pulse_trap
  // counts cycles from the request to an entry or a steal
  task automatic wait_ev(input bit steal);
    n = 1;
    #1;
    while ((steal ? cpu_steal : svc_entry) !== 1'b1 && n < 150) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({15'h0000, n < 150}, 16'h0001);
    v = svc_vector;
    x = xfer;
    @(posedge sys_clk);
  endtask : wait_ev
  task automatic idle_for(input int c);
    n = 0;
    repeat (c) begin
      @(posedge sys_clk);
      #1;
      if (svc_entry === 1'b1) n++;
    end
  endtask : idle_for
  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_latency();
    reg_rd(8'h05);
    chk(d, 16'h0000);
    reg_rd(8'hFF);
    chk(d, 16'h0000);
    reg_wr(8'h03, 16'h0105);
    pulse_node(3);
    wait_ev(1'b0);
    chk(16'(n), {8'h00, LAT_NOJC});
    chk({8'h00, v}, 16'h0003);
    reg_rd(8'h03);
    chk(d, 16'h0105);
    reg_wr(A_SYS_CTRL, 16'h0001);
    reg_wr(8'h03, 16'h0305);
    wait_ev(1'b0);
    chk(16'(n), {8'h00, LAT_JC});
    chk({8'h00, v}, 16'h0003);
  endtask : t_latency
  task automatic t_priority();
    reg_wr(8'h0A, 16'h0103);
    reg_wr(8'h14, 16'h0109);
    @(posedge sys_clk);
    dedicated_req <= 56'h00000000100400;
    @(posedge sys_clk);
    dedicated_req <= 56'h0;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0014);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h000A);
    @(posedge sys_clk);
    cpu_level <= 4'h9;
    pulse_node(20);
    idle_for(20);
    chk(16'(n), 16'h0000);
    @(posedge sys_clk);
    cpu_level <= 4'h2;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0014);
  endtask : t_priority
  task automatic t_event();
    reg_wr(8'h07, 16'h0154);
    reg_wr(A_CH + 8'h08, 16'h0202);
    reg_wr(A_CH + 8'h09, 16'h1000);
    reg_wr(A_CH + 8'h0A, 16'h2000);
    pulse_node(7);
    wait_ev(1'b1);
    chk(16'(n), 16'h0002);
    chk(x.src, 16'h1000);
    chk(x.dst, 16'h2000);
    pulse_node(7);
    wait_ev(1'b1);
    chk(x.src, 16'h1001);
    reg_rd(A_CH + 8'h08);
    chk(d, 16'h0200);
    pulse_node(7);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0007);
    reg_wr(8'h08, 16'h01B4);
    reg_wr(A_CH + 8'h14, 16'h0D01);
    reg_wr(A_CH + 8'h15, 16'h0010);
    reg_wr(A_CH + 8'h16, 16'h0100);
    repeat (2) begin
      pulse_node(8);
      wait_ev(1'b1);
    end
    chk(x.dst, 16'h0102);
    chk({15'h0000, x.word}, 16'h0001);
    reg_rd(A_CH + 8'h14);
    chk(d, 16'h0D01);
  endtask : t_event
  task automatic t_shared_router();
    reg_wr(A_SEL, 16'h0002);
    reg_wr(8'h3C, 16'h0106);
    @(posedge sys_clk);
    shared_req <= 16'h0002;
    @(posedge sys_clk);
    shared_req <= 16'h0004;
    @(posedge sys_clk);
    shared_req <= 16'h0000;
    wait_ev(1'b0);
    chk(16'(n), 16'h0007);
    chk({8'h00, v}, 16'h003C);
    reg_wr(8'h38, 16'h0106);
    reg_wr(8'h39, 16'h0106);
    reg_wr(8'h3A, 16'h0106);
    reg_wr(A_ROUTER, 16'h0005);
    reg_wr(A_ROUTER + 8'h01, 16'h000A);
    reg_wr(A_ROUTER + 8'h02, 16'h0C13);
    @(posedge sys_clk);
    ext_pin <= 4'h1;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0038);
    @(posedge sys_clk);
    ext_pin <= 4'h2;
    idle_for(20);
    chk(16'(n), 16'h0000);
    @(posedge sys_clk);
    ext_pin <= 4'h4;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0039);
    idle_for(20);
    chk(16'(n), 16'h0000);
    reg_wr(A_ROUTER + 8'h02, 16'h0893);
    @(posedge sys_clk);
    ext_pin <= 4'h0;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h003A);
    reg_wr(A_ROUTER + 8'h02, 16'h0453);
    @(posedge sys_clk);
    ext_pin <= 4'h5;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0038);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h003A);
  endtask : t_shared_router
  task automatic t_traps();
    @(posedge sys_clk);
    sw_trap_valid <= 1'b1;
    sw_trap_num <= 7'h25;
    @(posedge sys_clk);
    sw_trap_valid <= 1'b0;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0025);
    repeat (70) @(posedge sys_clk);
    pulse_trap(6'h04);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0042);
    reg_wr(8'h03, 16'h0305);
    idle_for(20);
    chk(16'(n), 16'h0000);
    pulse_trap(6'h10);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0044);
    pulse_trap(6'h02);
    idle_for(10);
    chk(16'(n), 16'h0000);
    reg_rd(A_TRAP_FLAG);
    chk(d, 16'h0016);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0041);
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0003);
    reg_wr(A_TRAP_FLAG, 16'h00FF);
    reg_rd(A_TRAP_FLAG);
    chk(d, 16'h0000);
    reg_wr(A_SYS_CTRL, 16'h0007);
    @(posedge sys_clk);
    external_service_request_pin <= 3'h4;
    idle_for(20);
    chk(16'(n), 16'h0000);
    @(posedge sys_clk);
    external_service_request_pin <= 3'h5;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0047);
    @(posedge sys_clk);
    external_service_request_pin <= 3'h7;
    wait_ev(1'b0);
    chk({8'h00, v}, 16'h0046);
  endtask : t_traps
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    dedicated_req = 56'h0;
    shared_req = 16'h0000;
    ext_pin = 4'h0;
    external_service_request_pin = 3'h0;
    hw_trap = {HW_TRAPS{1'b0}};
    sw_trap_valid = 1'b0;
    sw_trap_num = 7'h00;
    cpu_level = 4'h2;
    ret_wait = 8'h3C;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_latency();
    t_priority();
    t_event();
    t_shared_router();
    t_traps();
    complete_run();
  end
endmodule : testbench
bind interrupt_event_trap_system irq_checker chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .rd(rd), .rdata(rdata), .trap_ret(trap_ret), .svc_entry(svc_entry),
  .svc_vector(svc_vector), .cpu_steal(cpu_steal), .xfer(xfer));
